// *** logic/uifl_pkg.sv ***
// Register map, field positions and codes for the UART interrupt and format block
package uifl_pkg;
  // Word indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA   = 3'h0;
  localparam logic [2:0] IDX_IEN    = 3'h1;
  localparam logic [2:0] IDX_IDENT  = 3'h2;
  localparam logic [2:0] IDX_LFMT   = 3'h3;
  localparam logic [2:0] IDX_LSTAT  = 3'h5;
  localparam logic [2:0] IDX_MSTAT  = 3'h6;
  // Interrupt enable bits
  localparam int IEN_RX   = 0;
  localparam int IEN_TX   = 1;
  localparam int IEN_LS   = 2;
  localparam int IEN_MS   = 3;
  localparam logic [3:0] IEN_RESET = 4'h0;
  // FIFO control bits
  localparam int FC_EN    = 0;
  localparam int FC_RXRST = 1;
  localparam int FC_TXRST = 2;
  localparam int FC_DMA   = 3;
  localparam int FC_TRIG  = 6;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [4:0] TRIG_LVL0  = 5'h01;
  localparam logic [4:0] TRIG_LVL1  = 5'h04;
  localparam logic [4:0] TRIG_LVL2  = 5'h08;
  localparam logic [4:0] TRIG_LVL3  = 5'h0E;
  // Line format fields
  localparam int LF_STOP  = 2;
  localparam int LF_PAR   = 3;
  localparam logic [7:0] LFMT_RESET = 8'h00;
  // Identification codes, bits 3..0
  localparam logic [3:0] ID_LS   = 4'h6;
  localparam logic [3:0] ID_TO   = 4'hC;
  localparam logic [3:0] ID_RX   = 4'h4;
  localparam logic [3:0] ID_TX   = 4'h2;
  localparam logic [3:0] ID_MS   = 4'h0;
  localparam logic [3:0] ID_NONE = 4'h1;
  // Receive time-out span: four characters plus this many bit times
  localparam int TO_CHARS = 4;
  localparam int TO_BITS  = 12;
endpackage : uifl_pkg

// *** logic/uifl_top.sv ***
// Interrupt, FIFO control and line format logic of one UART channel
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - FIFO mode: receive interrupt and code while count at or above trigger.
// - Data ready set when a character enters the FIFO, cleared when empty.
// - FIFOs on with all enables off gives polled use of status flags.
// - Status bit 1 overrun, bits 2-4 head byte errors, bit 7 any FIFO error.
// - Status bit 5 transmit FIFO empty, bit 6 FIFO and shifter empty.
// - Non-FIFO mode: receive interrupt while holding register has a character.
// - Transmit-ready interrupt on transmit FIFO becoming empty; enable resets 0.
// - Overrun interrupts at once; other errors when character reaches the head.
// - Modem interrupt from any delta flag; enables reset 0; bits 7-4 reserved.
// - Identification read shows highest pending source; others stay queued.
// - Time-out after four character times plus twelve bit times.
// - Transmit-ready cleared by identification read or transmit data write.
// - Line status read, modem read, receive reads, data read clear their sources.
// - Codes: line status 0110, time-out 1100, receive data 0100.
// - Bit 0 low while pending, high when idle; bits 3-1 give source.
// - Bits 7 and 6 high while FIFOs enabled; bits 5 and 4 zero.
// - FIFO control bits other than enable taken only with enable written 1.
// - FIFO reset bits pulse pointer resets once and self-clear.
// - DMA mode bit changes behaviour of ready pins.
// - Trigger select 00,01,10,11 gives 1,4,8,14 characters.
// - Word length 00,01,10,11 gives 5,6,7,8 bits.
// - Stop bit field: 1, or 1.5 for 5-bit and 2 otherwise.
module uifl_top
  import uifl_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
)(
  input  wire  logic       CLOCK,
  input  wire  logic       RESET_N,
  input  wire  logic       WB_CYC_I,
  input  wire  logic       WB_STB_I,
  input  wire  logic       WB_WE_I,
  input  wire  logic [4:0] WB_ADR_I,
  input  wire  logic [3:0] WB_SEL_I,
  input  wire  logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire  logic [7:0] RX_DATA,
  input  wire  logic [4:0] RX_COUNT,
  input  wire  logic       RX_PUSH,
  input  wire  logic       RX_OVERRUN,
  input  wire  logic [2:0] RX_HEAD_ERR,
  input  wire  logic       RX_FIFO_ERR,
  input  wire  logic       TX_FIFO_EMPTY,
  input  wire  logic       TX_FIFO_FULL,
  input  wire  logic       TX_SHIFT_EMPTY,
  input  wire  logic       BIT_TICK,
  input  wire  logic [7:0] MODEM_STATUS,
  output logic             RX_READ,
  output logic             TX_WRITE,
  output logic [7:0]       TX_DATA,
  output logic             MODEM_READ,
  output logic             RX_FIFO_RESET,
  output logic             TX_FIFO_RESET,
  output logic             FIFO_ENABLE,
  output logic             DMA_MODE,
  output logic [1:0]       WORD_LENGTH,
  output logic [2:0]       STOP_HALF_BITS,
  output logic [7:0]       LINE_FORMAT,
  output logic             INTERRUPT,
  output logic             RECEIVE_READY_PIN_N,
  output logic             TRANSMIT_READY_PIN_N
);

  // Trigger 14 must fit, and the level port is only five bits wide
  if (FIFO_DEPTH < 14 || FIFO_DEPTH > 31)
  begin : g_depth_check
    $error("FIFO_DEPTH must lie in 14..31");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, ack drops after one cycle
  logic       acc;
  logic       wr;
  logic       rd;
  logic [2:0] idx;
  logic [3:0] ien;
  logic [1:0] trig_sel;
  logic [4:0] trig;
  logic       ovr;
  logic       ls_pend;
  logic       head_err_q;
  logic       tx_pend;
  logic       tx_empty_q;
  logic       to_flag;
  logic [7:0] to_cnt;
  logic [7:0] to_limit;
  logic       rx_int;
  logic       to_int;
  logic       ls_int;
  logic       tx_int;
  logic       ms_int;
  logic [3:0] ident;
  logic [7:0] line_stat;
  logic [7:0] next_rdata;

  assign acc = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr  = acc & WB_WE_I & WB_SEL_I[0];
  assign rd  = acc & ~WB_WE_I;
  assign idx = WB_ADR_I[4:2];

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= acc;
  end

  always_comb
  begin
    next_rdata = 8'h00;
    case (idx)
      IDX_DATA:  next_rdata = RX_DATA;
      IDX_IEN:   next_rdata = {4'h0, ien};
      IDX_IDENT: next_rdata = {{2{FIFO_ENABLE}}, 2'b00, ident};
      IDX_LFMT:  next_rdata = LINE_FORMAT;
      IDX_LSTAT: next_rdata = line_stat;
      IDX_MSTAT: next_rdata = MODEM_STATUS;
      default:   next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      WB_DAT_O <= 32'h0000_0000;
    else if (rd)
      WB_DAT_O <= {24'h00_0000, next_rdata};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access side effects, one-cycle pulses
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      RX_READ    <= 1'b0;
      TX_WRITE   <= 1'b0;
      MODEM_READ <= 1'b0;
    end
    else
    begin
      RX_READ    <= rd && idx == IDX_DATA;
      TX_WRITE   <= wr && idx == IDX_DATA;
      MODEM_READ <= rd && idx == IDX_MSTAT;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      TX_DATA <= 8'h00;
    else if (wr && idx == IDX_DATA)
      TX_DATA <= WB_DAT_I[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      ien <= IEN_RESET;
    else if (wr && idx == IDX_IEN)
      ien <= WB_DAT_I[3:0];
  end

  // Other fields are only taken when the enable bit is written as one
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      FIFO_ENABLE <= 1'b0;
      DMA_MODE    <= 1'b0;
      trig_sel    <= TRIG_RESET;
    end
    else if (wr && idx == IDX_IDENT)
    begin
      FIFO_ENABLE <= WB_DAT_I[FC_EN];
      if (WB_DAT_I[FC_EN])
      begin
        DMA_MODE <= WB_DAT_I[FC_DMA];
        trig_sel <= WB_DAT_I[FC_TRIG+:2];
      end
    end
  end

  // Reset bits act once and are never stored; a read of this index returns the identification
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      RX_FIFO_RESET <= 1'b0;
      TX_FIFO_RESET <= 1'b0;
    end
    else
    begin
      RX_FIFO_RESET <= wr && idx == IDX_IDENT && WB_DAT_I[FC_EN]
                       && WB_DAT_I[FC_RXRST];
      TX_FIFO_RESET <= wr && idx == IDX_IDENT && WB_DAT_I[FC_EN]
                       && WB_DAT_I[FC_TXRST];
    end
  end

  always_comb
  begin
    case (trig_sel)
      2'h0:    trig = TRIG_LVL0;
      2'h1:    trig = TRIG_LVL1;
      2'h2:    trig = TRIG_LVL2;
      default: trig = TRIG_LVL3;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      LINE_FORMAT <= LFMT_RESET;
    else if (wr && idx == IDX_LFMT)
      LINE_FORMAT <= WB_DAT_I[7:0];
  end

  assign WORD_LENGTH = LINE_FORMAT[1:0];
  // Stop length in half bit times
  assign STOP_HALF_BITS = !LINE_FORMAT[LF_STOP] ? 3'h2 :
                          (LINE_FORMAT[1:0] == 2'h0) ? 3'h3 : 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Line status
  // Overrun is sticky; a new overrun in the read cycle wins over the clear
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      ovr <= 1'b0;
    else if (RX_OVERRUN)
      ovr <= 1'b1;
    else if (rd && idx == IDX_LSTAT)
      ovr <= 1'b0;
  end

  assign line_stat = {FIFO_ENABLE & RX_FIFO_ERR,
                      TX_FIFO_EMPTY & TX_SHIFT_EMPTY,
                      TX_FIFO_EMPTY,
                      RX_HEAD_ERR,
                      ovr,
                      RX_COUNT != 5'h00};

  // Head errors interrupt when the bad character reaches the read position
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      head_err_q <= 1'b0;
      ls_pend    <= 1'b0;
    end
    else
    begin
      head_err_q <= |RX_HEAD_ERR;
      if (RX_OVERRUN || (|RX_HEAD_ERR && !head_err_q))
        ls_pend <= 1'b1;
      else if (rd && idx == IDX_LSTAT)
        ls_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive time-out timer, counted in bit ticks
  // Parity bit counted in; a half stop bit is rounded up to a whole one
  always_comb
  begin
    to_limit = 8'(TO_CHARS) * (8'h07 + {6'h00, LINE_FORMAT[1:0]}
               + {7'h00, LINE_FORMAT[LF_PAR]} + {7'h00, LINE_FORMAT[LF_STOP]})
               + 8'(TO_BITS);
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      to_cnt  <= 8'h00;
      to_flag <= 1'b0;
    end
    else if (RX_COUNT == 5'h00 || RX_PUSH || RX_READ)
    begin
      to_cnt  <= 8'h00;
      to_flag <= 1'b0;
    end
    else if (BIT_TICK && !to_flag)
    begin
      to_cnt <= to_cnt + 8'h01;
      if (to_cnt + 8'h01 == to_limit)
        to_flag <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit ready: set when the FIFO goes empty, set wins over clear
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      // Idle level of the empty flag, so release of reset is no false edge
      tx_empty_q <= 1'b1;
      tx_pend    <= 1'b0;
    end
    else
    begin
      tx_empty_q <= TX_FIFO_EMPTY;
      if (TX_FIFO_EMPTY && !tx_empty_q)
        tx_pend <= 1'b1;
      else if ((wr && idx == IDX_DATA)
               || (rd && idx == IDX_IDENT && ident == ID_TX))
        tx_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority and identification
  assign ls_int = ien[IEN_LS] & ls_pend;
  assign to_int = ien[IEN_RX] & FIFO_ENABLE & to_flag;
  assign rx_int = ien[IEN_RX] & (FIFO_ENABLE ? RX_COUNT >= trig
                                              : RX_COUNT != 5'h00);
  assign tx_int = ien[IEN_TX] & tx_pend;
  assign ms_int = ien[IEN_MS] & |MODEM_STATUS[3:0];

  // Lower sources stay pending behind the one reported
  always_comb
  begin
    if (ls_int)
      ident = ID_LS;
    else if (to_int)
      ident = ID_TO;
    else if (rx_int)
      ident = ID_RX;
    else if (tx_int)
      ident = ID_TX;
    else if (ms_int)
      ident = ID_MS;
    else
      ident = ID_NONE;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      INTERRUPT <= 1'b0;
    else
      INTERRUPT <= ~ident[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready pins: single-character signalling, or block signalling in DMA mode
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      RECEIVE_READY_PIN_N  <= 1'b1;
      TRANSMIT_READY_PIN_N <= 1'b1;
    end
    else
    begin
      RECEIVE_READY_PIN_N <= DMA_MODE ? !(RX_COUNT >= trig || to_flag)
                                      : RX_COUNT == 5'h00;
      TRANSMIT_READY_PIN_N <= DMA_MODE ? TX_FIFO_FULL
                                       : !TX_FIFO_EMPTY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_rx_level;
    @(posedge CLOCK) disable iff (!RESET_N)
    (ien[IEN_RX] && FIFO_ENABLE && !ls_int && !to_flag && RX_COUNT >= trig)
      |-> ident == ID_RX;
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("rx level code");

  property p_rx_below;
    @(posedge CLOCK) disable iff (!RESET_N)
    (FIFO_ENABLE && RX_COUNT < trig) |-> !rx_int;
  endproperty
  a_rx_below: assert property (p_rx_below) else $error("rx int below trig");

  property p_ovr_int;
    @(posedge CLOCK) disable iff (!RESET_N)
    (RX_OVERRUN && ien[IEN_LS]) |=> ident == ID_LS ##1 INTERRUPT;
  endproperty
  a_ovr_int: assert property (p_ovr_int) else $error("overrun no int");

  property p_ls_clear;
    @(posedge CLOCK) disable iff (!RESET_N)
    (rd && idx == IDX_LSTAT && !RX_OVERRUN && !(|RX_HEAD_ERR && !head_err_q))
      |=> !ls_pend && !ovr;
  endproperty
  a_ls_clear: assert property (p_ls_clear) else $error("ls not cleared");

  property p_tx_clear;
    @(posedge CLOCK) disable iff (!RESET_N)
    (wr && idx == IDX_DATA && !(TX_FIFO_EMPTY && !tx_empty_q)) |=> !tx_pend;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx not cleared");

  property p_fcr_ignore;
    @(posedge CLOCK) disable iff (!RESET_N)
    (wr && idx == IDX_IDENT && !WB_DAT_I[FC_EN])
      |=> $stable(trig_sel) && $stable(DMA_MODE) && !RX_FIFO_RESET;
  endproperty
  a_fcr_ignore: assert property (p_fcr_ignore) else $error("fcr not ignored");

  property p_fifo_rst;
    @(posedge CLOCK) disable iff (!RESET_N)
    RX_FIFO_RESET |=> !RX_FIFO_RESET;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("reset not self clear");

  property p_idle_code;
    @(posedge CLOCK) disable iff (!RESET_N)
    (ien == 4'h0) |-> ident == ID_NONE ##1 !INTERRUPT;
  endproperty
  a_idle_code: assert property (p_idle_code) else $error("polled mode int");

  property p_to_restart;
    @(posedge CLOCK) disable iff (!RESET_N)
    RX_PUSH |=> to_cnt == 8'h00 && !to_flag;
  endproperty
  a_to_restart: assert property (p_to_restart) else $error("timer no restart");

  property p_ack_pulse;
    @(posedge CLOCK) disable iff (!RESET_N)
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

endmodule : uifl_top
`default_nettype wire

// *** tb/uifl_far_model.sv ***
// Far-side model: receive and transmit FIFO levels, bit ticks, modem flags
`timescale 1ns/1ps
`default_nettype none
module uifl_far_model
(
  input  wire  logic       clock,
  input  wire  logic       reset_n,
  input  wire  logic       rx_read,
  input  wire  logic       tx_write,
  input  wire  logic       modem_read,
  input  wire  logic       rx_fifo_reset,
  input  wire  logic       tx_fifo_reset,
  input  wire  logic       push,
  input  wire  logic       ovr,
  input  wire  logic [3:0] delta,
  output logic [7:0]       rx_data,
  output logic [4:0]       rx_count,
  output logic             rx_push,
  output logic             rx_overrun,
  output logic             tx_fifo_empty,
  output logic             tx_fifo_full,
  output logic             tx_shift_empty,
  output logic             bit_tick,
  output logic [7:0]       modem_status
);
  logic [4:0] tx_cnt;
  logic [4:0] hold;
  logic [3:0] shift;
  logic [1:0] div;
  // Head byte changes with the level, so a stale capture shows up
  assign rx_data        = 8'hA0 + {3'h0, rx_count};
  assign tx_fifo_empty  = (tx_cnt == 5'h00);
  assign tx_fifo_full   = (tx_cnt == 5'h10);
  assign tx_shift_empty = (shift == 4'h0);
  assign bit_tick       = (div == 2'h3);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    div        <= reset_n ? div + 2'h1 : 2'h0;
    rx_push    <= reset_n & push;
    rx_overrun <= reset_n & ovr;
    if (!reset_n || rx_fifo_reset)
      rx_count <= 5'h00;
    else if (push && !rx_read)
      rx_count <= rx_count + 5'h01;
    else if (rx_read && !push && rx_count != 5'h00)
      rx_count <= rx_count - 5'h01;
  end
  // Slow drain, so the host sees the transmit FIFO busy for a while
  always_ff @(posedge clock)
  begin
    if (!reset_n || tx_fifo_reset)
      tx_cnt <= 5'h00;
    else if (tx_write)
      tx_cnt <= tx_cnt + 5'h01;
    else if (hold == 5'h00 && tx_cnt != 5'h00)
      tx_cnt <= tx_cnt - 5'h01;
    if (!reset_n || tx_write)
      hold <= 5'h14;
    else if (hold != 5'h00)
      hold <= hold - 5'h01;
    if (!reset_n)
      shift <= 4'h0;
    else if (hold == 5'h00 && tx_cnt != 5'h00 && !tx_write)
      shift <= 4'hF;
    else if (shift != 4'h0)
      shift <= shift - 4'h1;
  end
  // Delta flags stay until the host reads them
  always_ff @(posedge clock)
  begin
    if (!reset_n || modem_read)
      modem_status <= 8'h00;
    else
      modem_status <= modem_status | {4'h0, delta};
  end
endmodule : uifl_far_model
`default_nettype wire

// *** tb/uifl_top_tb.sv ***
// Self-checking bench for the UART interrupt, FIFO control and format block
`timescale 1ns/1ps
`default_nettype none
module uifl_top_tb;
  import uifl_pkg::*;
  typedef struct {logic [2:0] idx; logic [7:0] wd, rexp;
                  logic [1:0] wl; logic [2:0] st;} uifl_row_t;
  logic        clock, reset_n, cyc, stb, we, ack, push, ovr, ferr, irq, rx_pin_n, tx_pin_n;
  logic        rx_read, tx_write, m_read, rx_rst, tx_rst, fen, dma, rx_push, rx_ovr;
  logic        tx_empty, tx_full, sh_empty, tick;
  logic [4:0]  adr, rxc;
  logic [3:0]  sel, delta;
  logic [31:0] wdat, rdat;
  logic [2:0]  herr, stop;
  logic [1:0]  wl;
  logic [7:0]  rxd, txd, lfmt, mstat, rd, pv;
  int          miscompares, cmp_count;
  uifl_row_t   rows [10] = '{
    '{IDX_IEN, 8'hFF, 8'h0F, 2'h0, 3'h0}, '{IDX_IEN, 8'h05, 8'h05, 2'h0, 3'h0},
    '{3'h4, 8'hFF, 8'h00, 2'h0, 3'h0}, '{3'h7, 8'hFF, 8'h00, 2'h0, 3'h0},
    '{IDX_LFMT, 8'h04, 8'h04, 2'h0, 3'h3}, '{IDX_LFMT, 8'h05, 8'h05, 2'h1, 3'h4},
    '{IDX_LFMT, 8'h0E, 8'h0E, 2'h2, 3'h4}, '{IDX_LFMT, 8'h1F, 8'h1F, 2'h3, 3'h4},
    '{IDX_LFMT, 8'h01, 8'h01, 2'h1, 3'h2}, '{IDX_LFMT, 8'h00, 8'h00, 2'h0, 3'h2}};
  uifl_top i_uifl_top (.CLOCK(clock), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .RX_DATA(rxd), .RX_COUNT(rxc), .RX_PUSH(rx_push), .RX_OVERRUN(rx_ovr),
    .RX_HEAD_ERR(herr), .RX_FIFO_ERR(ferr), .TX_FIFO_EMPTY(tx_empty), .TX_FIFO_FULL(tx_full),
    .TX_SHIFT_EMPTY(sh_empty), .BIT_TICK(tick), .MODEM_STATUS(mstat), .RX_READ(rx_read),
    .TX_WRITE(tx_write), .TX_DATA(txd), .MODEM_READ(m_read), .RX_FIFO_RESET(rx_rst),
    .TX_FIFO_RESET(tx_rst), .FIFO_ENABLE(fen), .DMA_MODE(dma), .WORD_LENGTH(wl),
    .STOP_HALF_BITS(stop), .LINE_FORMAT(lfmt), .INTERRUPT(irq),
    .RECEIVE_READY_PIN_N(rx_pin_n), .TRANSMIT_READY_PIN_N(tx_pin_n));
  uifl_far_model i_uifl_far_model (.clock(clock), .reset_n(reset_n), .rx_read(rx_read),
    .tx_write(tx_write), .modem_read(m_read), .rx_fifo_reset(rx_rst), .tx_fifo_reset(tx_rst),
    .push(push), .ovr(ovr), .delta(delta), .rx_data(rxd), .rx_count(rxc), .rx_push(rx_push),
    .rx_overrun(rx_ovr), .tx_fifo_empty(tx_empty), .tx_fifo_full(tx_full),
    .tx_shift_empty(sh_empty), .bit_tick(tick), .modem_status(mstat));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic complete_run;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Classic cycle; read data and side-effect pulses taken at the ack edge
  task automatic wb(input logic w, input logic [2:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    @(posedge clock);
    // Only the watchdog ends a wait that never sees an answer
    while (ack !== 1'b1)
    begin
      @(posedge clock);
      n++;
    end
    chk("ack wait", 8'h01, 8'(n));
    rd = rdat[7:0];
    pv = {3'h0, rx_read, tx_write, m_read, rx_rst, tx_rst};
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clock);
  endtask : wb
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle
  task automatic pulse(input int what);
    if (what == 0) push <= 1'b1;
    else if (what == 1) ovr <= 1'b1;
    else delta <= 4'h2;
    @(posedge clock);
    push <= 1'b0;
    ovr <= 1'b0;
    delta <= 4'h0;
    idle(3);
  endtask : pulse
  task automatic ident(input logic [7:0] exp);
    wb(1'b0, IDX_IDENT, 8'h00);
    chk("ident", exp, rd);
  endtask : ident
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reset_n, cyc, stb, we, push, ovr, ferr} = 7'h00;
    {adr, sel, wdat, herr, delta} = {5'h00, 4'h1, 32'h0, 3'h0, 4'h0};
    miscompares = 0;
    cmp_count = 0;
    idle(20);
    reset_n <= 1'b1;
    idle(1);
    wb(1'b0, IDX_IEN, 8'h00);
    chk("ien", 8'h00, rd);
    ident(8'h01);
    chk("irq", 8'h00, 8'(irq));
    chk("fen", 8'h00, 8'(fen));
    $display("reset test done");
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].idx, rows[i].wd);
      wb(1'b0, rows[i].idx, 8'h00);
      chk("reg", rows[i].rexp, rd);
      if (rows[i].idx == IDX_LFMT)
      begin
        chk("wlen", {6'h0, rows[i].wl}, {6'h0, wl});
        chk("stop", {5'h0, rows[i].st}, {5'h0, stop});
        chk("lfmt", rows[i].rexp, lfmt);
      end
    end
    sel <= 4'hE;
    wb(1'b1, IDX_LFMT, 8'h03);
    sel <= 4'h1;
    wb(1'b0, IDX_LFMT, 8'h00);
    chk("lfmt sel", 8'h00, rd);
    $display("table test done");
    wb(1'b1, IDX_IDENT, 8'hCE);
    chk("ignored", 8'h00, {pv[5:0], fen, dma});
    wb(1'b1, IDX_IDENT, 8'h0F);
    chk("resets", 8'h03, pv);
    chk("dma", 8'h03, {6'h0, fen, dma});
    idle(2);
    chk("selfclr", 8'h00, {6'h0, rx_rst, tx_rst});
    ident(8'hC1);
    chk("pins", 8'h02, {6'h0, rx_pin_n, tx_pin_n});
    $display("fifo control test done");
    wb(1'b1, IDX_IDENT, 8'h41);
    wb(1'b1, IDX_IEN, 8'h01);
    repeat (3) pulse(0);
    ident(8'hC1);
    wb(1'b0, IDX_LSTAT, 8'h00);
    chk("lstat", 8'h61, rd);
    pulse(0);
    ident(8'hC4);
    chk("irq", 8'h01, 8'(irq));
    wb(1'b0, IDX_DATA, 8'h00);
    chk("rdpulse", 8'h10, pv);
    idle(2);
    ident(8'hC1);
    idle(125);
    ident(8'hC1);
    idle(50);
    ident(8'hCC);
    wb(1'b0, IDX_DATA, 8'h00);
    chk("data", 8'hA3, rd);
    idle(2);
    ident(8'hC1);
    $display("receive test done");
    wb(1'b1, IDX_IDENT, 8'h03);
    wb(1'b1, IDX_IEN, 8'h05);
    pulse(1);
    ident(8'hC6);
    pulse(0);
    ident(8'hC6);
    wb(1'b0, IDX_LSTAT, 8'h00);
    chk("lstat", 8'h63, rd);
    ident(8'hC4);
    herr <= 3'h4;
    ferr <= 1'b1;
    idle(3);
    ident(8'hC6);
    wb(1'b0, IDX_LSTAT, 8'h00);
    chk("lstat", 8'hF1, rd);
    herr <= 3'h0;
    ferr <= 1'b0;
    wb(1'b0, IDX_DATA, 8'h00);
    idle(2);
    ident(8'hC1);
    $display("line status test done");
    wb(1'b1, IDX_IDENT, 8'h83);
    repeat (7) pulse(0);
    ident(8'hC1);
    pulse(0);
    ident(8'hC4);
    wb(1'b1, IDX_IDENT, 8'hCB);
    repeat (13) pulse(0);
    ident(8'hC1);
    chk("dma pins", 8'h02, {6'h0, rx_pin_n, tx_pin_n});
    pulse(0);
    ident(8'hC4);
    chk("dma pins", 8'h00, {6'h0, rx_pin_n, tx_pin_n});
    wb(1'b1, IDX_IDENT, 8'h03);
    $display("trigger test done");
    wb(1'b1, IDX_IEN, 8'h02);
    wb(1'b1, IDX_DATA, 8'h5A);
    chk("txw", 8'h08, pv);
    chk("txd", 8'h5A, txd);
    wb(1'b0, IDX_LSTAT, 8'h00);
    chk("lstat", 8'h00, rd);
    chk("pins", 8'h03, {6'h0, rx_pin_n, tx_pin_n});
    chk("irq", 8'h00, 8'(irq));
    idle(40);
    chk("irq", 8'h01, 8'(irq));
    chk("pins", 8'h02, {6'h0, rx_pin_n, tx_pin_n});
    ident(8'hC2);
    ident(8'hC1);
    wb(1'b0, IDX_LSTAT, 8'h00);
    chk("lstat", 8'h60, rd);
    $display("transmit test done");
    wb(1'b1, IDX_IEN, 8'h08);
    pulse(2);
    ident(8'hC0);
    wb(1'b0, IDX_MSTAT, 8'h00);
    chk("modem", 8'h02, rd);
    chk("mread", 8'h04, pv);
    idle(2);
    ident(8'hC1);
    wb(1'b1, IDX_IEN, 8'h00);
    pulse(0);
    pulse(2);
    chk("irq", 8'h00, 8'(irq));
    wb(1'b0, IDX_LSTAT, 8'h00);
    chk("lstat", 8'h61, rd);
    $display("modem and polled test done");
    wb(1'b1, IDX_IDENT, 8'h00);
    wb(1'b1, IDX_IEN, 8'h01);
    idle(2);
    ident(8'h04);
    wb(1'b0, IDX_DATA, 8'h00);
    idle(2);
    ident(8'h01);
    $display("non-FIFO test done");
    wb(1'b1, IDX_LFMT, 8'h1F);
    reset_n <= 1'b0;
    idle(2);
    reset_n <= 1'b1;
    idle(1);
    wb(1'b0, IDX_LFMT, 8'h00);
    chk("lfmt rst", 8'h00, rd);
    wb(1'b0, IDX_IEN, 8'h00);
    chk("ien rst", 8'h00, rd);
    ident(8'h01);
    chk("fen rst", 8'h00, 8'(fen));
    $display("mid-run reset test done");
    complete_run();
  end
endmodule : uifl_top_tb
`default_nettype wire
